// [core/arc_defines.svh]
// Constants for the converter result and offset register block
// How it works
// - Differential scan bit k selects pair 2k/2k+1
// - Scan read of select returns result's channel
// - Signed offset corrects normal conversions, code 01
// - Calibration code 10 stores measured offset
// - Offset register read/write, rewritten value used
// - Hardware correction only in signed format
// - 12-bit offset in bits 7:2
// - 14-bit offset in bits 7:0
// - Result high read latches low, channel in scan only
// - Left: 8 MSBs; right 14-bit: bits 5:0
// - Right 12-bit: bits 3:0, held until next
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH

// ========================================
// Register indices, byte address is index times four
`define ARC_IDX_W 12
`define ARC_IDX_CTRL 12'hF70
`define ARC_IDX_INS_HIGH 12'hF71
`define ARC_IDX_INS_LOW 12'hF72
`define ARC_IDX_OFFSET 12'hF75
`define ARC_IDX_RES_HIGH 12'hF76
`define ARC_IDX_RES_LOW 12'hF77
`define ARC_IDX_NONE 12'hFFF

// ========================================
// Control register fields
`define ARC_CTRL_RES 0
`define ARC_CTRL_ALIGN 1
`define ARC_CTRL_SIGNED 2
`define ARC_CTRL_SCAN 3
`define ARC_CTRL_BUSY 6
`define ARC_CTRL_CODE_LO 4
`define ARC_CTRL_CODE_HI 5
`define ARC_INS_HIGH_MODE 0

// ========================================
// Start codes and reset values
`define ARC_CODE_IDLE 2'h0
`define ARC_CODE_NORMAL 2'h1
`define ARC_CODE_CAL 2'h2
`define ARC_RST_BYTE 8'h00
`define ARC_DIFF_MASK 8'h7F

`endif

// [core/arc_pkg.sv]
// Types shared by the converter result and offset register block
package arc_pkg;

	// ========================================
	// Complete state of the register block
	typedef struct packed {
		logic rdy;
		logic resp;
		logic [31:0] rdata;
		logic ap_rd;
		logic ap_wr;
		logic [11:0] ap_idx;
		logic res_sel;
		logic align;
		logic signed_fmt;
		logic scan_en;
		logic input_mode_select;
		logic [7:0] isl;
		logic [7:0] offset;
		logic [1:0] code;
		logic busy;
		logic start;
		logic [2:0] scan_pos;
		logic [4:0] chan;
		logic [7:0] res_hi;
		logic [7:0] held_lo;
		logic [4:0] held_chan;
		logic [7:0] res_lo;
		logic [4:0] rd_chan;
	} arc_state_t;

endpackage : arc_pkg

// [core/arc_regs.sv]
// Converter offset calibration and result registers on AHB-Lite
`timescale 1ns/1ns
`include "arc_defines.svh"

module arc_regs (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic conv_done_i,
	input wire logic [13:0] conv_raw_i,
	output logic conv_start_o,
	output logic [1:0] conv_code_o,
	output logic [4:0] conv_chan_o,
	output logic conv_diff_o
);

	arc_pkg::arc_state_t st_ff;
	arc_pkg::arc_state_t nxt_st;

	// ========================================
	// Helpers

	// Next set mask bit after the current one, wrapping round
	function automatic logic [2:0] next_scan(input logic [7:0] mask,
			input logic [2:0] cur);
		logic [2:0] pick;
		logic [2:0] cand;
		logic found;
		pick = cur;
		found = 1'b0;
		for (int i = 1; i <= 8; i++) begin
			cand = 3'(int'(cur) + i);
			if (!found && mask[cand]) begin
				pick = cand;
				found = 1'b1;
			end
		end
		return pick;
	endfunction : next_scan

	// Positive input of a scan entry
	function automatic logic [4:0] scan_chan(input logic [2:0] pos,
			input logic diff);
		if (diff)
			return {1'b0, pos, 1'b0};
		return {2'h0, pos};
	endfunction : scan_chan

	// Register index of a byte address; anything outside maps nowhere
	function automatic logic [11:0] reg_index(input logic [31:0] addr);
		logic [11:0] idx;
		idx = `ARC_IDX_NONE;
		if (addr[31:14] == 18'h0)
			idx = addr[13:2];
		return idx;
	endfunction : reg_index

	// Scan mask as hardware walks it; top pair bit is unused
	function automatic logic [7:0] scan_mask(input logic [7:0] isl,
			input logic diff);
		logic [7:0] m;
		m = isl;
		if (diff)
			m = isl & `ARC_DIFF_MASK;
		return m;
	endfunction : scan_mask

	// First channel of a software start
	function automatic logic [4:0] start_chan(input logic [7:0] isl,
			input logic [2:0] pos, input logic scan, input logic diff);
		logic [4:0] c;
		if (scan)
			c = scan_chan(pos, diff);
		else if (diff)
			c = {isl[4:1], 1'b0};
		else
			c = isl[4:0];
		return c;
	endfunction : start_chan

	// Calibration result in the offset register layout
	function automatic logic [7:0] cal_value(input logic [13:0] raw,
			input logic res14);
		if (res14)
			return raw[7:0];
		return {raw[5:0], 2'h0};
	endfunction : cal_value

	// High and low result bytes for each resolution and alignment
	function automatic logic [15:0] place_result(input logic [13:0] v,
			input logic res14, input logic right);
		logic [15:0] hl;
		case ({right, res14})
			2'h0:
				hl = {v[11:4], v[3:0], 4'h0};
			2'h1:
				hl = {v[13:6], v[5:0], 2'h0};
			2'h2:
				hl = {4'h0, v[11:8], v[7:0]};
			2'h3:
				hl = {2'h0, v[13:8], v[7:0]};
			default:
				hl = 16'h0000;
		endcase
		return hl;
	endfunction : place_result

	// Control register as software reads it back
	function automatic logic [7:0] ctrl_readback(
			input arc_pkg::arc_state_t s);
		logic [7:0] b;
		b = `ARC_RST_BYTE;
		b[`ARC_CTRL_RES] = s.res_sel;
		b[`ARC_CTRL_ALIGN] = s.align;
		b[`ARC_CTRL_SIGNED] = s.signed_fmt;
		b[`ARC_CTRL_SCAN] = s.scan_en;
		b[`ARC_CTRL_CODE_HI:`ARC_CTRL_CODE_LO] = s.code;
		b[`ARC_CTRL_BUSY] = s.busy;
		return b;
	endfunction : ctrl_readback

	// Scan position and channel after a finished entry
	function automatic logic [7:0] scan_step(input logic [7:0] isl,
			input logic [2:0] pos, input logic diff);
		logic [2:0] np;
		np = next_scan(scan_mask(isl, diff), pos);
		return {np, scan_chan(np, diff)};
	endfunction : scan_step

	// Byte that software reads at a register index
	function automatic logic [7:0] readback(input arc_pkg::arc_state_t s);
		logic [7:0] b;
		case (s.ap_idx)
			`ARC_IDX_CTRL:
				b = ctrl_readback(s);
			`ARC_IDX_INS_HIGH: begin
				b = `ARC_RST_BYTE;
				b[`ARC_INS_HIGH_MODE] = s.input_mode_select;
			end
			`ARC_IDX_INS_LOW: begin
				// Scan readback is the channel held for the result
				if (s.scan_en)
					b = {3'h0, s.rd_chan};
				else
					b = s.isl;
			end
			`ARC_IDX_OFFSET:
				b = s.offset;
			`ARC_IDX_RES_HIGH:
				b = s.res_hi;
			`ARC_IDX_RES_LOW:
				b = s.res_lo;
			default:
				b = `ARC_RST_BYTE;
		endcase
		return b;
	endfunction : readback

	// Converted value, 14-bit field, after any offset correction
	function automatic logic [13:0] corrected(input logic [13:0] raw,
			input logic [7:0] off, input logic res14, input logic apply);
		logic [13:0] adj;
		logic [13:0] val;
		if (res14) begin
			adj = {{6{off[7]}}, off};
			val = raw;
		end else begin
			adj = {{8{off[7]}}, off[7:2]};
			val = {2'h0, raw[11:0]};
		end
		// Two's complement wrap, no saturation
		if (apply)
			val = val - adj;
		if (!res14)
			val = {2'h0, val[11:0]};
		return val;
	endfunction : corrected

	// Datapath between the converter and the held bytes
	logic [13:0] conv_val;
	logic [15:0] hl_val;
	logic [7:0] lay_hi;
	logic [7:0] lay_lo;
	logic [7:0] cal_val;
	logic [7:0] rd_mux;
	logic [4:0] ns_chan;

	// Bus decode
	logic addr_ok;
	logic wr_now;
	logic rd_now;
	logic [7:0] wbyte;
	logic cal_done;
	logic [2:0] nxt_pos;
	logic [1:0] wcode;

	// ========================================
	// Result layout by resolution and alignment
	always_comb begin
		conv_val = corrected(conv_raw_i, st_ff.offset, st_ff.res_sel,
			st_ff.signed_fmt && st_ff.code == `ARC_CODE_NORMAL);
		cal_val = cal_value(conv_raw_i, st_ff.res_sel);
		hl_val = place_result(conv_val, st_ff.res_sel, st_ff.align);
		lay_hi = hl_val[15:8];
		lay_lo = hl_val[7:0];
	end

	// ========================================
	// Read data selection
	always_comb begin
		rd_mux = readback(st_ff);
	end

	// ========================================
	// Next state
	always_comb begin
		nxt_st = st_ff;
		addr_ok = hsel_i && htrans_i[1] && hready_i;
		wr_now = st_ff.ap_wr && hready_i;
		rd_now = st_ff.ap_rd && !st_ff.rdy;
		wbyte = hwdata_i[7:0];
		cal_done = 1'b0;
		nxt_pos = st_ff.scan_pos;
		ns_chan = scan_chan(st_ff.scan_pos, st_ff.input_mode_select);
		wcode = wbyte[`ARC_CTRL_CODE_HI:`ARC_CTRL_CODE_LO];

		// Pulses and the response fall back low every cycle
		nxt_st.start = 1'b0;
		nxt_st.resp = 1'b0;

		// Bus data phase of a write, zero wait
		if (wr_now) begin
			nxt_st.ap_wr = 1'b0;
			case (st_ff.ap_idx)
				`ARC_IDX_CTRL: begin
					nxt_st.res_sel = wbyte[`ARC_CTRL_RES];
					nxt_st.align = wbyte[`ARC_CTRL_ALIGN];
					nxt_st.signed_fmt = wbyte[`ARC_CTRL_SIGNED];
					nxt_st.scan_en = wbyte[`ARC_CTRL_SCAN];
					if (!st_ff.busy && wcode != `ARC_CODE_IDLE) begin
						nxt_st.code = wcode;
						nxt_st.busy = 1'b1;
						nxt_st.start = 1'b1;
						nxt_pos = next_scan(scan_mask(st_ff.isl, st_ff.input_mode_select),
							3'h7);
						nxt_st.scan_pos = nxt_pos;
						nxt_st.chan = start_chan(st_ff.isl, nxt_pos,
							wbyte[`ARC_CTRL_SCAN], st_ff.input_mode_select);
					end
				end
				`ARC_IDX_INS_HIGH:
					// Mode change drives conv_diff_o at once; channel choice follows at the next start
					nxt_st.input_mode_select = wbyte[`ARC_INS_HIGH_MODE];
				`ARC_IDX_INS_LOW:
					// Pairs stop at 12/13, so top bit is kept clear
					nxt_st.isl = st_ff.input_mode_select ?
						(wbyte & `ARC_DIFF_MASK) : wbyte;
				`ARC_IDX_OFFSET:
					// A same-cycle calibration result wins below
					nxt_st.offset = wbyte;
				default: begin
				end
			endcase
		end

		// Read completes one cycle late so writes are seen
		if (rd_now) begin
			nxt_st.ap_rd = 1'b0;
			nxt_st.rdy = 1'b1;
			nxt_st.rdata = {24'h0, rd_mux};
			// Low byte, and in scan the channel, follow the high byte read
			if (st_ff.ap_idx == `ARC_IDX_RES_HIGH) begin
				nxt_st.res_lo = st_ff.held_lo;
				if (st_ff.scan_en)
					nxt_st.rd_chan = st_ff.held_chan;
			end
		end

		// New address phase; a read data phase stalls the bus meanwhile
		if (addr_ok) begin
			nxt_st.ap_idx = reg_index(haddr_i);
			nxt_st.ap_wr = hwrite_i;
			nxt_st.ap_rd = !hwrite_i;
			if (!hwrite_i)
				nxt_st.rdy = 1'b0;
		end

		// Converter completion, hardware beats a same-cycle bus write
		if (conv_done_i && st_ff.busy) begin
			if (st_ff.code == `ARC_CODE_CAL) begin
				nxt_st.offset = cal_val;
				cal_done = 1'b1;
			end else begin
				nxt_st.res_hi = lay_hi;
				nxt_st.held_lo = lay_lo;
				nxt_st.held_chan = st_ff.chan;
			end
			// A normal-code scan goes straight on to the next entry; a calibration ends it
			if (st_ff.scan_en && !cal_done) begin
				{nxt_pos, ns_chan} = scan_step(st_ff.isl, st_ff.scan_pos,
					st_ff.input_mode_select);
				nxt_st.scan_pos = nxt_pos;
				nxt_st.chan = ns_chan;
				nxt_st.start = 1'b1;
			end else begin
				nxt_st.busy = 1'b0;
				nxt_st.code = `ARC_CODE_IDLE;
			end
		end
	end

	// ========================================
	// State register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			// Bus idles ready so the first address phase is taken
			st_ff.rdy <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ========================================
	// Outputs straight from the state register
	assign hreadyout_o = st_ff.rdy;
	// Response stays OKAY; unmapped accesses are simply ignored
	assign hresp_o = st_ff.resp;
	assign hrdata_o = st_ff.rdata;
	assign conv_start_o = st_ff.start;
	assign conv_code_o = st_ff.code;
	assign conv_chan_o = st_ff.chan;
	assign conv_diff_o = st_ff.input_mode_select;

endmodule : arc_regs

// [verif/arc_regs_asserts.sv]
// Assertion checker for the converter register block
`timescale 1ns/1ns
module arc_regs_chk (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [31:0] hrdata_o,
	input wire logic conv_done_i,
	input wire logic conv_start_o,
	input wire logic [1:0] conv_code_o,
	input wire logic [4:0] conv_chan_o,
	input wire logic conv_diff_o
);
	logic tk;
	assign tk = hsel_i & htrans_i[1] & hready_i;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ====
	// Bus and converter
	AST_RD_WAIT: assert property (
		tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	AST_WR_NOWAIT: assert property (
		tk && hwrite_i |=> hreadyout_o) else $error("write stalled");
	AST_DATA_HOLD: assert property (
		$changed(hrdata_o) |-> $rose(hreadyout_o))
		else $error("read data moved outside a read");
	AST_RESP_OKAY: assert property (
		!hresp_o) else $error("error response on bus");
	AST_HI_ZERO: assert property (
		hrdata_o[31:8] == 24'h0) else $error("upper read bits set");
	AST_START_PULSE: assert property (
		conv_start_o |=> !conv_start_o) else $error("start too long");
	AST_START_CODE: assert property (
		conv_start_o |-> conv_code_o == 2'h1 || conv_code_o == 2'h2)
		else $error("start with idle code");
	AST_CHAN_RANGE: assert property (
		conv_start_o && conv_diff_o |-> !conv_chan_o[0] && conv_chan_o <= 5'h0A)
		else $error("bad differential pair");
	AST_CODE_STABLE: assert property (
		$changed(conv_code_o) |-> conv_start_o || $past(conv_done_i))
		else $error("code changed without cause");
endmodule : arc_regs_chk

bind arc_regs arc_regs_chk u_arc_regs_chk (.mclk_i(mclk_i), .rst_i(rst_i),
	.hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.hrdata_o(hrdata_o),
	.conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
	.conv_code_o(conv_code_o), .conv_chan_o(conv_chan_o),
	.conv_diff_o(conv_diff_o));

// [verif/testbench.sv]
// Self-checking bench for the converter register block
`timescale 1ns/1ns
`include "arc_defines.svh"
module testbench;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic hwrite_i = 1'b0;
	logic conv_done_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [13:0] conv_raw_i = 14'h0;
	logic hreadyout_o, conv_start_o, conv_diff_o;
	logic [31:0] hrdata_o;
	logic [1:0] conv_code_o;
	logic [4:0] conv_chan_o;
	logic [7:0] q;
	logic [47:0] tb [6] = '{48'h2A5CA970A511, 48'h2A5CA5C0A510,
		48'h2A5C2A5CA513, 48'h2A5C0A5CA512, 48'h010000FC0417,
		48'h010000FF0416};
	int fail_count = 0;
	int n_checks = 0;
	int n;
	always #4 mclk_i = ~mclk_i;
	arc_regs u_arc_regs (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
		.hreadyout_o(hreadyout_o), .hresp_o(), .hrdata_o(hrdata_o),
		.conv_done_i(conv_done_i), .conv_raw_i(conv_raw_i),
		.conv_start_o(conv_start_o), .conv_code_o(conv_code_o),
		.conv_chan_o(conv_chan_o), .conv_diff_o(conv_diff_o));
	// ====
	// Tasks
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Sel picks start pulse or bus ready; bounded
	task wt(input logic sel);
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (!(sel ? conv_start_o : hreadyout_o) && n < 20);
		if (n == 20) begin
			fail_count++;
			conclude();
		end
	endtask : wt
	task xfer(input logic w, input logic [11:0] i, input logic [7:0] d);
		hsel_i <= 1'b1;
		haddr_i <= {18'h0, i, 2'h0};
		htrans_i <= 2'h2;
		hwrite_i <= w;
		wt(1'b0);
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, d};
		wt(1'b0);
		q = hrdata_o[7:0];
	endtask : xfer
	task rchk(input logic [11:0] i, input logic [7:0] e);
		xfer(1'b0, i, 8'h00);
		chk(q, e);
	endtask : rchk
	task done(input logic [13:0] r);
		conv_done_i <= 1'b1;
		conv_raw_i <= r;
		@(posedge mclk_i);
		conv_done_i <= 1'b0;
	endtask : done
	task run(input logic [7:0] c, input logic [13:0] r);
		xfer(1'b1, `ARC_IDX_CTRL, c);
		wt(1'b1);
		chk({6'h0, conv_code_o}, {6'h0, c[5:4]});
		done(r);
	endtask : run
	// ====
	// Sequence
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		rchk(`ARC_IDX_OFFSET, 8'h00);
		xfer(1'b1, `ARC_IDX_RES_HIGH, 8'h5A);
		rchk(`ARC_IDX_RES_HIGH, 8'h00);
		xfer(1'b1, 12'h000, 8'h77);
		rchk(12'h000, 8'h00);
		for (int k = 0; k < 6; k++) begin
			xfer(1'b1, `ARC_IDX_OFFSET, tb[k][15:8]);
			rchk(`ARC_IDX_OFFSET, tb[k][15:8]);
			run(tb[k][7:0], tb[k][45:32]);
			rchk(`ARC_IDX_RES_HIGH, tb[k][31:24]);
			rchk(`ARC_IDX_RES_LOW, tb[k][23:16]);
		end
		run(8'h21, 14'h0037);
		rchk(`ARC_IDX_OFFSET, 8'h37);
		run(8'h20, 14'h0015);
		rchk(`ARC_IDX_OFFSET, 8'h54);
		xfer(1'b1, `ARC_IDX_OFFSET, 8'h00);
		rchk(`ARC_IDX_OFFSET, 8'h00);
		run(8'h11, 14'h0040);
		rchk(`ARC_IDX_RES_HIGH, 8'h01);
		xfer(1'b1, `ARC_IDX_INS_HIGH, 8'h01);
		xfer(1'b1, `ARC_IDX_INS_LOW, 8'h22);
		xfer(1'b1, `ARC_IDX_CTRL, 8'h19);
		wt(1'b1);
		for (int k = 0; k < 2; k++) begin
			chk({2'h0, conv_diff_o, conv_chan_o}, k ? 8'h2A : 8'h22);
			done(14'h0);
			wt(1'b1);
			rchk(`ARC_IDX_RES_HIGH, 8'h00);
			rchk(`ARC_IDX_INS_LOW, k ? 8'h0A : 8'h02);
		end
		conclude();
	end
endmodule : testbench
